// ### design/rts_sequencer.sv
`timescale 1ns/1ns
module rts_sequencer
  import rts_pkg::*;
#(
  parameter int unsigned PwrtTicks    = POWERUP_DELAY_TIMER_TICKS,
  parameter int unsigned OstPeriods   = OST_PERIODS,
  parameter int unsigned BorMinCycles = BOR_MIN_CYCLES
) (
  // Clock and reset
  clk,
  rst_n,
  // Supply monitors and pins
  powerOnPulse,
  brownoutDetect,
  masterClear_n,
  lowFreqInternalOsc,
  oscClockIn,
  // Configuration fuses
  powerupTimerDisable,
  brownoutModeSelect,
  oscModeSelect,
  // Core events
  sleepEnter,
  wakeEvent,
  watchdogTimeout,
  // Reset output
  coreReset_n,
  // APB slave
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr
);

  input  wire logic        clk;
  input  wire logic        rst_n;
  input  wire logic        powerOnPulse;
  input  wire logic        brownoutDetect;
  input  wire logic        masterClear_n;
  input  wire logic        lowFreqInternalOsc;
  input  wire logic        oscClockIn;
  input  wire logic        powerupTimerDisable;
  input  wire logic [1:0]  brownoutModeSelect;
  input  wire logic [2:0]  oscModeSelect;
  input  wire logic        sleepEnter;
  input  wire logic        wakeEvent;
  input  wire logic        watchdogTimeout;
  output logic             coreReset_n;
  input  wire logic        psel;
  input  wire logic        penable;
  input  wire logic        pwrite;
  input  wire logic [11:0] paddr;
  input  wire logic [31:0] pwdata;
  output logic [31:0]      prdata;
  output logic             pready;
  output logic             pslverr;

  typedef struct packed {
    rts_state_t            state;
    logic [POWERUP_DELAY_TIMER_CNT_W-1:0] pwrtCnt;
    logic [OST_CNT_W-1:0]  ostCnt;
    logic [BOR_CNT_W-1:0]  borCnt;
    logic                  brownoutFlag_n;
    logic                  powerOnFlag_n;
    logic                  brownoutSwEnable;
    logic                  timeoutFlag_n;
    logic                  powerDownFlag_n;
    logic                  coreReset_n;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } rts_core_t;

  rts_core_t  s;
  rts_core_t  next_s;
  rts_sync_if syn ();

  logic       crystalMode;
  logic       pwrtEnable;
  logic       borEnable;
  logic       brownTrip;
  logic       apbSetup;
  logic       apbWrite;
  logic [9:0] regIdx;
  logic       idxPcon;
  logic       idxStatus;
  logic       idxState;

  rts_input_sync u_sync (
    .clk                (clk),
    .rst_n              (rst_n),
    .powerOnPulse       (powerOnPulse),
    .brownoutDetect     (brownoutDetect),
    .masterClear_n      (masterClear_n),
    .lowFreqInternalOsc (lowFreqInternalOsc),
    .oscClockIn         (oscClockIn),
    .syn                (syn.sync)
  );

  always_comb begin
    crystalMode = (oscModeSelect == OSC_LOW_POWER_XTAL) || (oscModeSelect == OSC_CRYSTAL)
                  || (oscModeSelect == OSC_HIGH_SPEED);
    pwrtEnable  = ~powerupTimerDisable;
    unique case (brownoutModeSelect)
      BOR_ALWAYS:     borEnable = 1'b1;
      BOR_AWAKE_ONLY: borEnable = (s.state != ST_SLEEP);
      BOR_SOFTWARE:   borEnable = s.brownoutSwEnable;
      BOR_OFF:        borEnable = 1'b0;
    endcase
    // Dips shorter than the minimum never reach the trip count
    brownTrip = borEnable && syn.lowSupply
                && (s.borCnt >= BOR_CNT_W'(BorMinCycles));
    regIdx    = paddr[11:2];
    idxPcon   = (regIdx == {2'b00, POWER_CONTROL_IDX});
    idxStatus = (regIdx == {2'b00, CORE_STATUS_IDX});
    idxState  = (regIdx == {2'b00, SEQ_STATE_IDX});
    apbSetup  = psel && !penable;
    apbWrite  = psel && penable && s.pready && pwrite && !s.pslverr;
  end

  always_comb begin
    next_s = s;

    // Brown-out duration filter
    if (borEnable && syn.lowSupply) begin
      if (s.borCnt < BOR_CNT_W'(BorMinCycles)) begin
        next_s.borCnt = s.borCnt + 1'b1;
      end
    end else begin
      next_s.borCnt = '0;
    end

    // Software writes come first so hardware events below win
    if (apbWrite && idxPcon) begin
      next_s.brownoutFlag_n   = pwdata[POWER_CONTROL_REG_BROWN_BIT];
      next_s.powerOnFlag_n    = pwdata[POWER_CONTROL_REG_POWER_BIT];
      next_s.brownoutSwEnable = pwdata[POWER_CONTROL_REG_SWEN_BIT];
    end

    unique case (s.state)
      ST_POR: begin
        next_s.pwrtCnt = '0;
        next_s.ostCnt  = '0;
        if (!syn.porActive) begin
          next_s.state = ST_BROWN;
        end
      end
      ST_BROWN: begin
        next_s.pwrtCnt = '0;
        next_s.ostCnt  = '0;
        if (!(syn.lowSupply && borEnable)) begin
          if (pwrtEnable) begin
            next_s.state = ST_POWERUP_DELAY_TIMER;
          end else if (crystalMode) begin
            next_s.state = ST_OST;
          end else begin
            next_s.state = ST_RUN;
          end
        end
      end
      ST_POWERUP_DELAY_TIMER: begin
        if (syn.lfTick) begin
          next_s.pwrtCnt = s.pwrtCnt + 1'b1;
        end
        if (syn.lfTick && (s.pwrtCnt == POWERUP_DELAY_TIMER_CNT_W'(PwrtTicks - 1))) begin
          next_s.state = crystalMode ? ST_OST : ST_RUN;
        end
      end
      ST_OST: begin
        if (syn.oscTick) begin
          next_s.ostCnt = s.ostCnt + 1'b1;
        end
        if (syn.oscTick && (s.ostCnt == OST_CNT_W'(OstPeriods - 1))) begin
          next_s.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!syn.masterClear_n) begin
          next_s.brownoutSwEnable = SWEN_RESET;
        end else if (watchdogTimeout) begin
          next_s.timeoutFlag_n    = 1'b0;
          next_s.brownoutSwEnable = SWEN_RESET;
          next_s.state            = ST_WDTRST;
        end else if (sleepEnter) begin
          next_s.timeoutFlag_n   = 1'b1;
          next_s.powerDownFlag_n = 1'b0;
          next_s.state           = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        next_s.ostCnt = '0;
        if (!syn.masterClear_n) begin
          next_s.timeoutFlag_n    = 1'b1;
          next_s.powerDownFlag_n  = 1'b0;
          next_s.brownoutSwEnable = SWEN_RESET;
          next_s.state            = ST_RUN;
        end else if (watchdogTimeout || wakeEvent) begin
          if (watchdogTimeout) begin
            next_s.timeoutFlag_n   = 1'b0;
            next_s.powerDownFlag_n = 1'b0;
          end
          next_s.state = crystalMode ? ST_OST : ST_RUN;
        end
      end
      ST_WDTRST: begin
        next_s.state = ST_RUN;
      end
      default: begin
        next_s.state = ST_POR;
      end
    endcase

    // Brown-out restarts the whole sequence, including a running delay
    if (brownTrip && (s.state != ST_POR) && (s.state != ST_BROWN)) begin
      next_s.state            = ST_BROWN;
      next_s.pwrtCnt          = '0;
      next_s.brownoutFlag_n   = 1'b0;
      next_s.timeoutFlag_n    = 1'b1;
      next_s.powerDownFlag_n  = 1'b1;
      next_s.brownoutSwEnable = SWEN_RESET;
    end

    // Power-on dominates every other source
    if (syn.porActive) begin
      next_s.state            = ST_POR;
      next_s.pwrtCnt          = '0;
      next_s.powerOnFlag_n    = 1'b0;
      next_s.timeoutFlag_n    = 1'b1;
      next_s.powerDownFlag_n  = 1'b1;
      next_s.brownoutSwEnable = SWEN_RESET;
    end

    // Held in reset while any time-out runs; master clear only gates release
    next_s.coreReset_n = ((next_s.state == ST_RUN) || (next_s.state == ST_SLEEP))
                         && syn.masterClear_n;

    // APB answers in the access cycle after every setup cycle
    next_s.pready  = apbSetup;
    next_s.pslverr = apbSetup && !(idxPcon || idxStatus || (idxState && !pwrite));
    next_s.prdata  = '0;
    if (apbSetup && !pwrite) begin
      if (idxPcon) begin
        next_s.prdata[POWER_CONTROL_REG_BROWN_BIT] = s.brownoutFlag_n;
        next_s.prdata[POWER_CONTROL_REG_POWER_BIT] = s.powerOnFlag_n;
        next_s.prdata[POWER_CONTROL_REG_SWEN_BIT]  = s.brownoutSwEnable;
      end else if (idxStatus) begin
        next_s.prdata[STAT_TO_BIT] = s.timeoutFlag_n;
        next_s.prdata[STAT_PD_BIT] = s.powerDownFlag_n;
      end else if (idxState) begin
        next_s.prdata[2:0] = s.state;
        next_s.prdata[3]   = s.coreReset_n;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s                  <= '0;
      s.state            <= ST_POR;
      s.brownoutFlag_n   <= 1'b1;
      s.brownoutSwEnable <= SWEN_RESET;
      s.timeoutFlag_n    <= 1'b1;
      s.powerDownFlag_n  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign coreReset_n = s.coreReset_n;
  assign prdata      = s.prdata;
  assign pready      = s.pready;
  assign pslverr     = s.pslverr;

endmodule // rts_sequencer

// ### inc/rts_pkg.sv
package rts_pkg;

  // Timer clock and delays
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned LFOSC_HZ          = 31_000;
  localparam int unsigned POWERUP_DELAY_TIMER_TIME_US      = 64_000;
  localparam int unsigned POWERUP_DELAY_TIMER_TICKS        = (POWERUP_DELAY_TIMER_TIME_US / 1000) * LFOSC_HZ / 1000;
  localparam int unsigned OST_PERIODS       = 1024;
  localparam int unsigned BOR_MIN_TIME_NS   = 100_000;
  localparam int unsigned CLK_PERIOD_NS     = 1_000_000_000 / CLK_HZ;
  localparam int unsigned BOR_MIN_CYCLES    = (BOR_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_DELAY_TIMER_CNT_W        = 12;
  localparam int unsigned OST_CNT_W         = 11;
  localparam int unsigned BOR_CNT_W         = 16;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  POWER_CONTROL_IDX = 8'h8E;
  localparam logic [7:0]  CORE_STATUS_IDX   = 8'h03;
  localparam logic [7:0]  SEQ_STATE_IDX     = 8'h90;

  // Power control fields
  localparam int unsigned POWER_CONTROL_REG_BROWN_BIT    = 0;
  localparam int unsigned POWER_CONTROL_REG_POWER_BIT    = 1;
  localparam int unsigned POWER_CONTROL_REG_SWEN_BIT     = 4;
  localparam logic        SWEN_RESET        = 1'b1;

  // Core status fields
  localparam int unsigned STAT_PD_BIT       = 3;
  localparam int unsigned STAT_TO_BIT       = 4;

  // Brown-out mode select encodings
  localparam logic [1:0]  BOR_OFF           = 2'b00;
  localparam logic [1:0]  BOR_SOFTWARE      = 2'b01;
  localparam logic [1:0]  BOR_AWAKE_ONLY    = 2'b10;
  localparam logic [1:0]  BOR_ALWAYS        = 2'b11;

  // Oscillator mode encodings
  localparam logic [2:0]  OSC_LOW_POWER_XTAL = 3'b000;
  localparam logic [2:0]  OSC_CRYSTAL        = 3'b001;
  localparam logic [2:0]  OSC_HIGH_SPEED     = 3'b010;
  localparam logic [2:0]  OSC_EXTERNAL_CLOCK = 3'b011;

  typedef enum logic [2:0] {
    ST_POR    = 3'b000,
    ST_BROWN  = 3'b001,
    ST_POWERUP_DELAY_TIMER   = 3'b010,
    ST_OST    = 3'b011,
    ST_RUN    = 3'b100,
    ST_SLEEP  = 3'b101,
    ST_WDTRST = 3'b110
  } rts_state_t;

endpackage

// ### inc/rts_sync_if.sv
`timescale 1ns/1ns
interface rts_sync_if;
  logic porActive;
  logic lowSupply;
  logic masterClear_n;
  logic lfTick;
  logic oscTick;

  modport sync (output porActive, output lowSupply, output masterClear_n,
                output lfTick, output oscTick);
  modport core (input porActive, input lowSupply, input masterClear_n,
                input lfTick, input oscTick);
endinterface

// ### design/rts_input_sync.sv
`timescale 1ns/1ns
module rts_input_sync
  import rts_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Raw asynchronous inputs
  input  wire logic powerOnPulse,
  input  wire logic brownoutDetect,
  input  wire logic masterClear_n,
  input  wire logic lowFreqInternalOsc,
  input  wire logic oscClockIn,
  // Synchronised outputs
  rts_sync_if.sync  syn
);

  typedef struct packed {
    logic [4:0] stage1;
    logic [4:0] stage2;
    logic [1:0] stage3;
  } rts_sync_t;

  rts_sync_t s;
  rts_sync_t next_s;

  always_comb begin
    next_s        = s;
    next_s.stage1 = {oscClockIn, lowFreqInternalOsc, masterClear_n, brownoutDetect, powerOnPulse};
    next_s.stage2 = s.stage1;
    next_s.stage3 = s.stage2[4:3];
  end

  // Power-on taken as active, master clear as idle, until real samples arrive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{stage1: 5'b0_0101, stage2: 5'b0_0101, stage3: 2'b00};
    end else begin
      s <= next_s;
    end
  end

  assign syn.porActive     = s.stage2[0];
  assign syn.lowSupply     = s.stage2[1];
  assign syn.masterClear_n = s.stage2[2];
  // Edge detect reads only the second stage and later
  assign syn.lfTick        = s.stage2[3] & ~s.stage3[0];
  assign syn.oscTick       = s.stage2[4] & ~s.stage3[1];

endmodule // rts_input_sync

// ### verif/rts_sequencer_sva.sv
`timescale 1ns/1ns
module rts_sequencer_sva
  import rts_pkg::*;
#(
  parameter int unsigned PwrtTicks    = POWERUP_DELAY_TIMER_TICKS,
  parameter int unsigned OstPeriods   = OST_PERIODS,
  parameter int unsigned BorMinCycles = BOR_MIN_CYCLES
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Pins, fuses and core reset
  input wire logic        powerOnPulse,
  input wire logic        brownoutDetect,
  input wire logic        masterClear_n,
  input wire logic        lowFreqInternalOsc,
  input wire logic        oscClockIn,
  input wire logic        powerupTimerDisable,
  input wire logic [1:0]  brownoutModeSelect,
  input wire logic [2:0]  oscModeSelect,
  input wire logic        coreReset_n,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic [15:0] lfCnt, oscCnt, lowCnt;
  logic        lfPrev, oscPrev, badAddr, extQuick;

  assign badAddr = paddr != 12'h238 && paddr != 12'h00C && !(paddr == 12'h240 && !pwrite);
  assign extQuick = masterClear_n && powerupTimerDisable && !brownoutDetect
                    && oscModeSelect == OSC_EXTERNAL_CLOCK;

  // Raw edge counts run ahead of the synchronised ones, so lower bounds stay safe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfPrev <= 1'b0;
      oscPrev <= 1'b0;
      lfCnt <= '0;
      oscCnt <= '0;
      lowCnt <= '0;
    end else begin
      lfPrev <= lowFreqInternalOsc;
      oscPrev <= oscClockIn;
      lfCnt <= powerOnPulse ? '0 : lfCnt + 16'(lowFreqInternalOsc && !lfPrev && !(&lfCnt));
      oscCnt <= powerOnPulse ? '0 : oscCnt + 16'(oscClockIn && !oscPrev && !(&oscCnt));
      lowCnt <= brownoutDetect ? lowCnt + 16'(!(&lowCnt)) : '0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence setupPhase;
    psel && !penable;
  endsequence
  sequence porHeld;
    powerOnPulse [*5];
  endsequence

  a_apb_answer: assert property (setupPhase |=> pready)
    else $error("No answer after setup");
  a_apb_single: assert property (pready |=> !pready)
    else $error("Ready held two cycles");
  a_bad_index: assert property (setupPhase ##0 badAddr |=> pslverr && prdata == '0)
    else $error("Bad index not refused");
  a_power_control_reg_clean: assert property (setupPhase ##0 paddr == 12'h238 |=> !pslverr)
    else $error("Power control access refused");
  a_por_hold: assert property (porHeld |-> !coreReset_n)
    else $error("Core out of reset during power-on");
  a_master_clear_n_hold: assert property (!masterClear_n [*5] |-> !coreReset_n)
    else $error("Core out of reset with pin low");
  a_delay_min: assert property ($rose(coreReset_n) && !powerupTimerDisable |-> lfCnt >= PwrtTicks)
    else $error("Power-up delay cut short");
  a_ost_min: assert property ($rose(coreReset_n) && oscModeSelect < OSC_EXTERNAL_CLOCK
      |-> oscCnt >= OstPeriods)
    else $error("Oscillator start-up cut short");
  a_brown_rst: assert property (lowCnt > BorMinCycles + 6 && brownoutModeSelect == BOR_ALWAYS
      |-> !coreReset_n)
    else $error("Long brown-out gave no reset");
  a_ext_fast: assert property ($fell(powerOnPulse) && extQuick |-> ##[1:12] coreReset_n)
    else $error("External clock start delayed");
endmodule // rts_sequencer_sva

bind rts_sequencer rts_sequencer_sva #(
  .PwrtTicks(PwrtTicks), .OstPeriods(OstPeriods), .BorMinCycles(BorMinCycles)
) u_sva (
  .clk(clk), .rst_n(rst_n), .powerOnPulse(powerOnPulse), .brownoutDetect(brownoutDetect),
  .masterClear_n(masterClear_n), .lowFreqInternalOsc(lowFreqInternalOsc),
  .oscClockIn(oscClockIn), .powerupTimerDisable(powerupTimerDisable),
  .brownoutModeSelect(brownoutModeSelect), .oscModeSelect(oscModeSelect),
  .coreReset_n(coreReset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

// ### verif/rts_supply_model.sv
`timescale 1ns/1ns
module rts_supply_model #(
  parameter int LfHalf  = 4,
  parameter int OscHalf = 2
) (
  // Clock
  input wire logic clk,
  // Free-running oscillators
  output logic     lowFreqInternalOsc,
  output logic     oscClockIn
);
  int lfDiv = 0;
  int oscDiv = 0;

  initial begin
    lowFreqInternalOsc = 1'b0;
    oscClockIn = 1'b0;
  end
  // Slow clock well below half the system rate, as the sampler needs
  always @(posedge clk) begin
    lfDiv <= (lfDiv == LfHalf - 1) ? 0 : lfDiv + 1;
    oscDiv <= (oscDiv == OscHalf - 1) ? 0 : oscDiv + 1;
    if (lfDiv == LfHalf - 1) lowFreqInternalOsc <= !lowFreqInternalOsc;
    if (oscDiv == OscHalf - 1) oscClockIn <= !oscClockIn;
  end
endmodule // rts_supply_model

// ### verif/reset_timeout_sequencer_tb_top.sv
`timescale 1ns/1ns
module reset_timeout_sequencer_tb_top
  import rts_pkg::*;
;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} rts_row_t;
  logic        clk, rst_n, powerOnPulse, brownoutDetect, masterClear_n, powerupTimerDisable;
  logic        sleepEnter, wakeEvent, watchdogTimeout, coreReset_n, lfOsc, oscIn;
  logic        psel, penable, pwrite, pready, pslverr, er;
  logic [1:0]  brownoutModeSelect;
  logic [2:0]  oscModeSelect;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          errorCnt = 0, nCompared = 0, cyc = 0, n;
  rts_row_t    rows [9] = '{
    '{12'h238, 1'b0, 32'h0000_0000, 32'h0000_0011, 1'b0}, '{12'h238, 1'b1, 32'h0000_0013, '0, 1'b0},
    '{12'h238, 1'b0, 32'h0000_0000, 32'h0000_0013, 1'b0}, '{12'h00C, 1'b0, '0, 32'h0000_0018, 1'b0},
    '{12'h00C, 1'b1, 32'h0000_0000, '0, 1'b0}, '{12'h00C, 1'b0, '0, 32'h0000_0018, 1'b0},
    '{12'h240, 1'b0, 32'h0000_0000, 32'h0000_000C, 1'b0}, '{12'h240, 1'b1, '0, '0, 1'b1},
    '{12'h100, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1}};
  logic [2:0]  puOm [4] = '{3'h7, 3'h3, 3'h1, 3'h7};
  logic        puDis [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  int          puHold [4] = '{0, 0, 0, 200}, puLo [4] = '{56, 0, 12, 0}, puHi [4] = '{110, 12, 40, 8};
  logic [1:0]  mdSel [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
  logic        mdSw [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1}, mdRst [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  rts_supply_model u_model (.clk(clk), .lowFreqInternalOsc(lfOsc), .oscClockIn(oscIn));
  rts_sequencer #(.PwrtTicks(8), .OstPeriods(4), .BorMinCycles(4)) dut (
    .clk(clk), .rst_n(rst_n), .powerOnPulse(powerOnPulse), .brownoutDetect(brownoutDetect),
    .masterClear_n(masterClear_n), .lowFreqInternalOsc(lfOsc), .oscClockIn(oscIn),
    .powerupTimerDisable(powerupTimerDisable), .brownoutModeSelect(brownoutModeSelect),
    .oscModeSelect(oscModeSelect), .sleepEnter(sleepEnter), .wakeEvent(wakeEvent),
    .watchdogTimeout(watchdogTimeout), .coreReset_n(coreReset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  task automatic chkWord(input logic [31:0] g, input logic [31:0] x);
    nCompared++;
    if (g !== x) begin
      errorCnt++;
      $display("[FAIL] %0t value %h expected %h", $time, g, x);
    end
  endtask
  task automatic chkRange(input int g, input int lo, input int hi);
    nCompared++;
    if (g < lo || g > hi) begin
      errorCnt++;
      $display("[FAIL] %0t cycles %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Request held until ready is seen high at the closing edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    // Values read here are those sampled at this edge; only the bench timeout ends the wait
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic waitUp();
    n = 0;
    @(negedge clk);
    while (coreReset_n !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic puRun(input int i);
    @(posedge clk);
    {powerupTimerDisable, oscModeSelect, powerOnPulse} <= {puDis[i], puOm[i], 1'b1};
    masterClear_n <= (puHold[i] == 0);
    repeat (5) @(posedge clk);
    powerOnPulse <= 1'b0;
    repeat (puHold[i]) @(posedge clk);
    masterClear_n <= 1'b1;
    waitUp();
    chkRange(n, puLo[i], puHi[i]);
    $display("test power-up %0d done", i);
  endtask
  task automatic brown(input int len);
    @(posedge clk);
    brownoutDetect <= 1'b1;
    repeat (len) @(posedge clk);
    brownoutDetect <= 1'b0;
    @(negedge clk);
  endtask
  task automatic evt(input logic wdt);
    @(posedge clk);
    {watchdogTimeout, sleepEnter} <= {wdt, !wdt};
    @(posedge clk);
    {watchdogTimeout, sleepEnter} <= 2'b00;
    repeat (6) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errorCnt++;
      results();
    end
  end

  initial begin
    {rst_n, powerOnPulse, brownoutDetect, masterClear_n, powerupTimerDisable} = 5'b01010;
    {sleepEnter, wakeEvent, watchdogTimeout, psel, penable, pwrite} = '0;
    {brownoutModeSelect, oscModeSelect, paddr, pwdata} = {BOR_ALWAYS, 3'h7, 12'h000, 32'h0};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    puRun(0);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      chkWord({31'h0, er}, {31'h0, rows[i].e});
      if (!rows[i].w) chkWord(rd, rows[i].x);
    end
    $display("test register table done");
    foreach (mdSel[i]) begin
      @(posedge clk);
      brownoutModeSelect <= mdSel[i];
      apb(12'h238, 1'b1, {27'h0, mdSw[i], 4'h3});
      brown(20);
      chkWord({31'h0, !coreReset_n}, {31'h0, mdRst[i]});
      waitUp();
      if (mdRst[i]) chkRange(n, 56, 110);
      apb(12'h238, 1'b0, '0);
      if (mdRst[i]) chkWord(rd, 32'h0000_0012);
    end
    $display("test brown-out modes done");
    brownoutModeSelect <= BOR_ALWAYS;
    brown(20);
    repeat (30) @(posedge clk);
    brown(20);
    waitUp();
    chkRange(n, 56, 110);
    $display("test delay restart done");
    brownoutModeSelect <= BOR_AWAKE_ONLY;
    evt(1'b1);
    apb(12'h00C, 1'b0, '0);
    chkWord(rd, 32'h0000_0008);
    evt(1'b0);
    apb(12'h00C, 1'b0, '0);
    chkWord(rd, 32'h0000_0010);
    brown(20);
    chkWord({31'h0, coreReset_n}, 32'h0000_0001);
    evt(1'b1);
    apb(12'h00C, 1'b0, '0);
    chkWord(rd, 32'h0000_0000);
    masterClear_n <= 1'b0;
    repeat (10) @(posedge clk);
    chkWord({31'h0, coreReset_n}, 32'h0000_0000);
    apb(12'h00C, 1'b0, '0);
    chkWord(rd, 32'h0000_0000);
    masterClear_n <= 1'b1;
    waitUp();
    chkRange(n, 0, 6);
    // Crystal wake runs the oscillator start-up count
    oscModeSelect <= OSC_CRYSTAL;
    evt(1'b0);
    wakeEvent <= 1'b1;
    @(posedge clk);
    wakeEvent <= 1'b0;
    waitUp();
    chkRange(n, 12, 40);
    evt(1'b0);
    masterClear_n <= 1'b0;
    repeat (10) @(posedge clk);
    apb(12'h240, 1'b0, '0);
    chkWord(rd, 32'h0000_0004);
    apb(12'h00C, 1'b0, '0);
    chkWord(rd, 32'h0000_0010);
    masterClear_n <= 1'b1;
    waitUp();
    chkRange(n, 0, 6);
    $display("test sleep and watchdog done");
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chkWord({31'h0, coreReset_n}, 32'h0000_0000);
    @(posedge clk);
    rst_n <= 1'b1;
    apb(12'h238, 1'b0, '0);
    chkWord(rd, 32'h0000_0011);
    $display("test mid-run reset done");
    for (int i = 1; i < 4; i++) puRun(i);
    results();
  end
endmodule // reset_timeout_sequencer_tb_top
